//--- logic/dcrs_top.sv
// Purpose: channel configuration, bus release and request routing of a four-channel dma controller
// Assumes: axi4-lite slave on aclk, request and bus inputs synchronous to aclk
// Notes: channel step and width outputs follow the channel selected by active_channel
//
// Behaviour
// - release enabled and bus owned: yield bus after current dma cycle ends
// - release disabled: ignore core release requests and keep the bus
// - bit 9 selects source type, 1 io, 0 memory, resets 0
// - bits 8:7 source step: 00 increment, 01 decrement, 1x fixed
// - bit 6 selects destination type, 1 io, 0 memory, resets 0
// - bits 3:2 transfer size: 11 byte, 10 two bytes, 0x four bytes
// - bits 1:0 io port width, same encoding as transfer size
// - port width is ignored on memory to memory transfers
// - select bit 3: channel 3 request from pin if 1, else interrupt controller
// - select bit 2: channel 2 request from pin if 1, else interrupt controller
// - request mode 1 takes external requests, 0 takes software requests
// - release enable acts only with the plain bus request, not snoop
`timescale 1ns/10ps
module dcrs_top (
    input wire logic aclk, // system clock, 250 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [1:0] active_channel, // channel now served
    input wire logic bus_need, // active channel wants the bus
    input wire logic bus_grant, // core has granted the bus
    input wire logic core_release_request, // core asks for the bus back
    input wire logic dma_cycle_active, // a dma bus cycle is in progress
    output logic plain_bus_request, // non-snoop bus request
    output logic snoop_bus_request, // snoop bus request
    output logic bus_yield_done, // bus handed back to the core
    input wire logic [3:0] interrupt_controller, // per-channel requests from the interrupt controller
    input wire logic ch2_request_pin, // channel 2 request pin, asserted high
    input wire logic ch3_request_pin, // channel 3 request pin, asserted high
    input wire logic [3:0] software_request, // per-channel internal requests
    output logic [3:0] channel_request_r, // routed request per channel
    output logic [31:0] src_step_r, // source address change per cycle
    output logic [31:0] dst_step_r, // destination address change per cycle
    output logic [2:0] xfer_bytes_r, // bytes moved per request
    output logic [1:0] src_cycle_width_r, // width code of source bus cycles
    output logic [1:0] dst_cycle_width_r, // width code of destination bus cycles
    output logic src_is_io_r, // source is an io device
    output logic dst_is_io_r // destination is an io device
);
    // write channel state
    logic aw_held_r;
    logic [7:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    // read channel state
    logic rd_pend_r;
    logic [7:0] rd_addr_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    // registers
    logic [31:0] req_sel_r;
    logic [31:0] req_sel_nxt;
    dcrs_pkg::dcrs_arb_type arb_r;
    dcrs_pkg::dcrs_arb_type arb_nxt;
    dcrs_pkg::dcrs_wr_type mem_wr;
    logic [31:0] mem_rd_data;
    logic [dcrs_pkg::NUM_CH-1:0][31:0] ctrl_words;

    function automatic logic is_ch_addr(input logic [7:0] a);
        return (a <= dcrs_pkg::CH_CTRL_LAST) && (a[1:0] == dcrs_pkg::ADDR_ALIGN);
    endfunction

    // write path: address and data may arrive in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
    wire wr_to_ch = wr_fire && is_ch_addr(aw_addr_r);
    wire wr_to_sel = wr_fire && (aw_addr_r == dcrs_pkg::REQ_SEL_OFF);
    wire wr_ok = wr_to_ch || wr_to_sel;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    assign mem_wr.en = wr_to_ch;
    assign mem_wr.idx = aw_addr_r[dcrs_pkg::CH_IDX_LO +: 2];
    assign mem_wr.data = w_data_r;
    assign mem_wr.strb = w_strb_r;

    // undefined select bits are masked off and read as zero
    assign req_sel_nxt = wr_to_sel
        ? dcrs_pkg::merge_word(req_sel_r, w_data_r, w_strb_r, dcrs_pkg::REQ_SEL_MASK)
        : req_sel_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= dcrs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? dcrs_pkg::RESP_OKAY : dcrs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_sel_r <= dcrs_pkg::REQ_SEL_RESET;
        end else begin
            req_sel_r <= req_sel_nxt;
        end
    end

    wire ar_take = s_axi_arvalid && s_axi_arready;

    dcrs_cfg_mem u_cfg_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(mem_wr),
        .rd_en(ar_take),
        .rd_idx(s_axi_araddr[dcrs_pkg::CH_IDX_LO +: 2]),
        .rd_data_r(mem_rd_data),
        .words(ctrl_words)
    );

    // read path: address taken, then one cycle for the memory read
    wire rd_is_ch = is_ch_addr(rd_addr_r);
    wire rd_is_sel = rd_addr_r == dcrs_pkg::REQ_SEL_OFF;
    wire rd_is_state = rd_addr_r == dcrs_pkg::STATE_OFF;
    wire [31:0] state_word = {24'h0, channel_request_r, 1'b0, arb_r};
    wire [31:0] rd_word = rd_is_ch ? mem_rd_data
                        : rd_is_sel ? req_sel_r
                        : rd_is_state ? state_word
                        : 32'h0;
    wire rd_mapped = rd_is_ch || rd_is_sel || rd_is_state;

    assign s_axi_arready = !rd_pend_r && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h0;
        end else if (ar_take) begin
            rd_pend_r <= 1'b1;
            rd_addr_r <= s_axi_araddr;
        end else begin
            rd_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= dcrs_pkg::RESP_OKAY;
            rdata_r <= 32'h0;
        end else if (rd_pend_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_mapped ? dcrs_pkg::RESP_OKAY : dcrs_pkg::RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // decode of the channel now served
    dcrs_pkg::dcrs_cfg_type act_cfg;
    assign act_cfg = dcrs_pkg::unpack_cfg(ctrl_words[active_channel]);

    wire [2:0] act_bytes = dcrs_pkg::size_bytes(act_cfg.transfer_size);
    wire [31:0] act_src_step = dcrs_pkg::step_value(act_cfg.source_step_mode, act_bytes);
    wire [31:0] act_dst_step =
        dcrs_pkg::step_value(act_cfg.destination_step_mode, act_bytes);
    // memory sides run at transfer size, so port width only matters on io sides
    wire [1:0] act_src_width = act_cfg.source_is_io
        ? act_cfg.io_port_width : act_cfg.transfer_size;
    wire [1:0] act_dst_width = act_cfg.destination_is_io
        ? act_cfg.io_port_width : act_cfg.transfer_size;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_step_r <= 32'h0;
            dst_step_r <= 32'h0;
            xfer_bytes_r <= dcrs_pkg::BYTES_4;
            src_cycle_width_r <= 2'h0;
            dst_cycle_width_r <= 2'h0;
            src_is_io_r <= 1'b0;
            dst_is_io_r <= 1'b0;
        end else begin
            src_step_r <= act_src_step;
            dst_step_r <= act_dst_step;
            xfer_bytes_r <= act_bytes;
            src_cycle_width_r <= act_src_width;
            dst_cycle_width_r <= act_dst_width;
            src_is_io_r <= act_cfg.source_is_io;
            dst_is_io_r <= act_cfg.destination_is_io;
        end
    end

    // request routing
    logic [3:0] ext_request;
    logic [3:0] mode_ext;
    logic [3:0] routed_request;

    assign ext_request[0] = interrupt_controller[0];
    assign ext_request[1] = interrupt_controller[1];
    assign ext_request[2] = req_sel_r[dcrs_pkg::CH2_SEL_BIT]
        ? ch2_request_pin : interrupt_controller[2];
    assign ext_request[3] = req_sel_r[dcrs_pkg::CH3_SEL_BIT]
        ? ch3_request_pin : interrupt_controller[3];

    always_comb begin
        mode_ext = 4'h0;
        for (int i = 0; i < dcrs_pkg::NUM_CH; i++) begin
            mode_ext[i] = ctrl_words[i][dcrs_pkg::REQ_MODE_BIT];
        end
    end

    assign routed_request = (mode_ext & ext_request) | (~mode_ext & software_request);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_request_r <= 4'h0;
        end else begin
            channel_request_r <= routed_request;
        end
    end

    // bus ownership and release to the core
    wire release_honoured = act_cfg.bus_release_enable && !act_cfg.snoop
        && core_release_request;
    wire req_on = ((arb_r == dcrs_pkg::ARB_IDLE) && bus_need)
               || (arb_r == dcrs_pkg::ARB_OWN)
               || ((arb_r == dcrs_pkg::ARB_YIELD) && dma_cycle_active);

    assign plain_bus_request = req_on && !act_cfg.snoop;
    assign snoop_bus_request = req_on && act_cfg.snoop;
    assign bus_yield_done = (arb_r == dcrs_pkg::ARB_YIELD) && !dma_cycle_active;

    always_comb begin
        arb_nxt = arb_r;
        case (arb_r)
            dcrs_pkg::ARB_IDLE: begin
                if (bus_need && bus_grant) begin
                    arb_nxt = dcrs_pkg::ARB_OWN;
                end
            end
            dcrs_pkg::ARB_OWN: begin
                if (release_honoured) begin
                    arb_nxt = dcrs_pkg::ARB_YIELD;
                end else if (!bus_need) begin
                    arb_nxt = dcrs_pkg::ARB_IDLE;
                end
            end
            dcrs_pkg::ARB_YIELD: begin
                // stay off the bus until the core withdraws its request
                if (!dma_cycle_active && !core_release_request) begin
                    arb_nxt = dcrs_pkg::ARB_IDLE;
                end
            end
            default: begin
                arb_nxt = dcrs_pkg::ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_r <= dcrs_pkg::ARB_IDLE;
        end else begin
            arb_r <= arb_nxt;
        end
    end
endmodule

//--- logic/dcrs_pkg.sv
// Purpose: constants, types and helpers of the dma channel config and request select block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: unprinted offsets and field positions are named here once
package dcrs_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int CH_IDX_LO = 2;
    localparam logic [7:0] CH_CTRL_LAST = 8'h0c;
    localparam logic [7:0] REQ_SEL_OFF = 8'h10;
    localparam logic [7:0] STATE_OFF = 8'h14;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;
    localparam logic [31:0] CH_CTRL_MASK = 32'h0000_7fff;
    localparam logic [31:0] REQ_SEL_MASK = 32'h0000_000c;
    localparam logic [31:0] CH_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] REQ_SEL_RESET = 32'h0000_0000;
    localparam int REQ_MODE_BIT = 14;
    localparam int SNOOP_BIT = 11;
    localparam int RELEASE_BIT = 10;
    localparam int SRC_IO_BIT = 9;
    localparam int SRC_STEP_LO = 7;
    localparam int DST_IO_BIT = 6;
    localparam int DST_STEP_LO = 4;
    localparam int XFER_SIZE_LO = 2;
    localparam int PORT_W_LO = 0;
    localparam int CH2_SEL_BIT = 2;
    localparam int CH3_SEL_BIT = 3;
    localparam int STATE_REQ_LO = 4;
    localparam logic [1:0] STEP_INC = 2'h0;
    localparam logic [1:0] STEP_DEC = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h3;
    localparam logic [1:0] SIZE_HALF = 2'h2;
    localparam logic [2:0] BYTES_1 = 3'h1;
    localparam logic [2:0] BYTES_2 = 3'h2;
    localparam logic [2:0] BYTES_4 = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic request_mode_external;
        logic snoop;
        logic bus_release_enable;
        logic source_is_io;
        logic [1:0] source_step_mode;
        logic destination_is_io;
        logic [1:0] destination_step_mode;
        logic [1:0] transfer_size;
        logic [1:0] io_port_width;
    } dcrs_cfg_type;

    typedef struct packed {
        logic en;
        logic [1:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } dcrs_wr_type;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_OWN = 3'b010,
        ARB_YIELD = 3'b100
    } dcrs_arb_type;

    function automatic dcrs_cfg_type unpack_cfg(input logic [31:0] w);
        dcrs_cfg_type c;
        c.request_mode_external = w[REQ_MODE_BIT];
        c.snoop = w[SNOOP_BIT];
        c.bus_release_enable = w[RELEASE_BIT];
        c.source_is_io = w[SRC_IO_BIT];
        c.source_step_mode = w[SRC_STEP_LO +: 2];
        c.destination_is_io = w[DST_IO_BIT];
        c.destination_step_mode = w[DST_STEP_LO +: 2];
        c.transfer_size = w[XFER_SIZE_LO +: 2];
        c.io_port_width = w[PORT_W_LO +: 2];
        return c;
    endfunction

    // byte-lane merge, bits outside mask always read back as zero
    function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    function automatic logic [2:0] size_bytes(input logic [1:0] code);
        if (code == SIZE_BYTE) begin
            return BYTES_1;
        end else if (code == SIZE_HALF) begin
            return BYTES_2;
        end else begin
            return BYTES_4;
        end
    endfunction

    function automatic logic [31:0] step_value(input logic [1:0] mode, input logic [2:0] bytes);
        if (mode == STEP_INC) begin
            return {29'h0, bytes};
        end else if (mode == STEP_DEC) begin
            return 32'h0 - {29'h0, bytes};
        end else begin
            return 32'h0;
        end
    endfunction
endpackage

//--- logic/dcrs_cfg_mem.sv
// Purpose: storage of the four channel control words
// Assumes: one write port, one registered read port
// Notes: all words are also visible as flops for the decode logic
`timescale 1ns/10ps
module dcrs_cfg_mem (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire dcrs_pkg::dcrs_wr_type wr, // masked byte write
    input wire logic rd_en, // read strobe
    input wire logic [1:0] rd_idx, // read word index
    output logic [31:0] rd_data_r, // registered read data
    output logic [dcrs_pkg::NUM_CH-1:0][31:0] words // live contents
);
    logic [dcrs_pkg::NUM_CH-1:0][31:0] mem_r;

    assign words = mem_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < dcrs_pkg::NUM_CH; i++) begin
                mem_r[i] <= dcrs_pkg::CH_CTRL_RESET;
            end
        end else if (wr.en) begin
            mem_r[wr.idx] <= dcrs_pkg::merge_word(mem_r[wr.idx], wr.data, wr.strb,
                                                  dcrs_pkg::CH_CTRL_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data_r <= 32'h0;
        end else if (rd_en) begin
            rd_data_r <= mem_r[rd_idx];
        end
    end
endmodule

//--- verif/dcrs_props.sv
// Purpose: port-level checks of dcrs_top
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound from the bench
`timescale 1ns/10ps
module dcrs_props (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic dma_cycle_active, // dma cycle
    input wire logic plain_bus_request, // plain req
    input wire logic snoop_bus_request, // snoop req
    input wire logic bus_yield_done, // yielded
    input wire logic [2:0] xfer_bytes_r, // bytes
    input wire logic [31:0] src_step_r, // src step
    input wire logic [31:0] dst_step_r, // dst step
    input wire logic [1:0] src_cycle_width_r, // src width
    input wire logic [1:0] dst_cycle_width_r, // dst width
    input wire logic src_is_io_r, // src io
    input wire logic dst_is_io_r // dst io
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_YIELD_QUIET: assert property (
        bus_yield_done |-> !dma_cycle_active && !plain_bus_request && !snoop_bus_request)
        else $error("yield while busy");
    AST_ONE_REQUEST: assert property (
        !(plain_bus_request && snoop_bus_request)) else $error("both bus requests high");
    AST_XFER_BYTES: assert property (
        xfer_bytes_r == 3'h1 || xfer_bytes_r == 3'h2 || xfer_bytes_r == 3'h4)
        else $error("bad byte count");
    AST_SRC_STEP: assert property (
        src_step_r == 32'h0 || src_step_r == {29'h0, xfer_bytes_r}
        || src_step_r == 32'h0 - {29'h0, xfer_bytes_r}) else $error("bad source step");
    AST_DST_STEP: assert property (
        dst_step_r == 32'h0 || dst_step_r == {29'h0, xfer_bytes_r}
        || dst_step_r == 32'h0 - {29'h0, xfer_bytes_r}) else $error("bad destination step");
    AST_SRC_MEM_WIDTH: assert property (
        !src_is_io_r |-> (src_cycle_width_r == 2'h3) == (xfer_bytes_r == 3'h1)
        && (src_cycle_width_r == 2'h2) == (xfer_bytes_r == 3'h2)) else $error("src width");
    AST_DST_MEM_WIDTH: assert property (
        !dst_is_io_r |-> (dst_cycle_width_r == 2'h3) == (xfer_bytes_r == 3'h1)
        && (dst_cycle_width_r == 2'h2) == (xfer_bytes_r == 3'h2)) else $error("dst width");
    AST_READ_LATENCY: assert property (
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid) else $error("read answer late");
    AST_WRITE_LATENCY: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_WRITE_REFUSE: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_READ_REFUSE: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
endmodule

//--- verif/dcrs_core_model.sv
// Purpose: processor core side of the shared bus
// Assumes: grant follows any request one cycle later
// Notes: dma cycles run three busy clocks then one idle clock
`timescale 1ns/10ps
module dcrs_core_model (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic release_cmd, // bench wants the core to reclaim the bus
    input wire logic plain_bus_request, // non-snoop request
    input wire logic snoop_bus_request, // snoop request
    output logic bus_grant, // grant
    output logic core_release_request, // release request
    output logic dma_cycle_active // dma bus cycle running
);
    logic [1:0] cnt_r;

    assign dma_cycle_active = bus_grant && (cnt_r != 2'h3);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_grant <= 1'b0;
            core_release_request <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            bus_grant <= plain_bus_request || snoop_bus_request;
            core_release_request <= release_cmd;
            cnt_r <= bus_grant ? cnt_r + 2'h1 : 2'h0;
        end
    end
endmodule

//--- verif/dcrs_top_tb.sv
// Purpose: self-checking bench of dcrs_top
// Assumes: axi4-lite master tasks, core model on the bus side
// Notes: handshakes are sampled at the falling edge, driven at the rising edge
`timescale 1ns/10ps
module dcrs_top_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, src_step_r, dst_step_r;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, src_cycle_width_r, dst_cycle_width_r;
    logic [1:0] active_channel = 2'h0;
    logic bus_need = 1'b0, ch2_request_pin = 1'b0, ch3_request_pin = 1'b0, release_cmd = 1'b0;
    logic [3:0] interrupt_controller = 4'h0, software_request = 4'h0, channel_request_r;
    logic bus_grant, core_release_request, dma_cycle_active;
    logic plain_bus_request, snoop_bus_request, bus_yield_done, src_is_io_r, dst_is_io_r;
    logic [2:0] xfer_bytes_r;
    int fail_count = 0;
    int total_checks = 0;

    always #2 aclk = ~aclk;

    dcrs_top u_dut (.*);
    dcrs_core_model u_core (.*);

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [2:0] nbytes(input logic [1:0] sz);
        return (sz == 2'h3) ? 3'h1 : (sz == 2'h2) ? 3'h2 : 3'h4;
    endfunction

    function automatic logic [31:0] nstep(input logic [1:0] m, input logic [2:0] b);
        return m[1] ? 32'h0 : m[0] ? 32'h0 - {29'h0, b} : {29'h0, b};
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh = 1'b0;
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bh && n < 50) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            if (bh) chk("bresp", 32'(s_axi_bresp), 32'(er));
            n++;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end
        if (!bh) chk("wr_tmo", 32'h0, 32'h1);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ah, rh = 1'b0;
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rh && n < 50) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            if (rh) chk("rdata", s_axi_rdata, ed);
            if (rh) chk("rresp", 32'(s_axi_rresp), 32'(er));
            n++;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
        if (!rh) chk("rd_tmo", 32'h0, 32'h1);
    endtask

    task automatic bus_case(input logic [31:0] w, input logic exp_yield, input logic snp);
        int y = 0;
        axi_wr(8'h04, w, dcrs_pkg::RESP_OKAY);
        @(posedge aclk);
        active_channel <= 2'h1;
        bus_need <= 1'b1;
        repeat (4) @(posedge aclk);
        #1;
        chk("req_kind", 32'({snoop_bus_request, plain_bus_request}), 32'({snp, !snp}));
        @(posedge aclk);
        release_cmd <= 1'b1;
        repeat (20) begin
            @(negedge aclk);
            if (bus_yield_done) y++;
        end
        chk("yielded", 32'(y != 0), 32'(exp_yield));
        @(posedge aclk);
        release_cmd <= 1'b0;
        bus_need <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h00, 32'h0, dcrs_pkg::RESP_OKAY);
        axi_rd(8'h10, 32'h0, dcrs_pkg::RESP_OKAY);
        axi_wr(8'h18, 32'hffff_ffff, dcrs_pkg::RESP_SLVERR);
        axi_rd(8'h18, 32'h0, dcrs_pkg::RESP_SLVERR);
        axi_wr(8'h14, 32'h1, dcrs_pkg::RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            logic [31:0] w;
            w = {22'h0, i[0], 2'(i), i[1], 2'(3 - i), 2'(i), 2'(3 - i)};
            axi_wr(8'(4 * i), w, dcrs_pkg::RESP_OKAY);
            axi_rd(8'(4 * i), w, dcrs_pkg::RESP_OKAY);
            @(posedge aclk);
            active_channel <= 2'(i);
            repeat (2) @(posedge aclk);
            #1;
            chk("xfer_bytes", 32'(xfer_bytes_r), 32'(nbytes(w[3:2])));
            chk("src_step", src_step_r, nstep(w[8:7], nbytes(w[3:2])));
            chk("dst_step", dst_step_r, nstep(w[5:4], nbytes(w[3:2])));
            chk("src_io", 32'(src_is_io_r), 32'(w[9]));
            chk("dst_io", 32'(dst_is_io_r), 32'(w[6]));
            chk("src_width", 32'(src_cycle_width_r), 32'(w[9] ? w[1:0] : w[3:2]));
            chk("dst_width", 32'(dst_cycle_width_r), 32'(w[6] ? w[1:0] : w[3:2]));
        end
        for (int c = 0; c < 4; c++) axi_wr(8'(4 * c), c ? 32'h4000 : 32'h0, 2'h0);
        for (int s = 0; s < 2; s++) begin
            axi_wr(8'h10, s ? 32'hc : 32'h0, dcrs_pkg::RESP_OKAY);
            axi_rd(8'h10, s ? 32'hc : 32'h0, dcrs_pkg::RESP_OKAY);
            for (int v = 0; v < 2; v++) begin
                logic [3:0] e;
                @(posedge aclk);
                interrupt_controller <= v ? 4'h9 : 4'h6;
                software_request <= v ? 4'he : 4'h1;
                ch2_request_pin <= v[0];
                ch3_request_pin <= !v[0];
                repeat (2) @(posedge aclk);
                #1;
                e = {s ? ch3_request_pin : interrupt_controller[3],
                    s ? ch2_request_pin : interrupt_controller[2],
                    interrupt_controller[1], software_request[0]};
                chk("route", 32'(channel_request_r), 32'(e));
            end
        end
        bus_case(32'h400, 1'b1, 1'b0);
        bus_case(32'h0, 1'b0, 1'b0);
        bus_case(32'hc00, 1'b0, 1'b1);
        give_verdict();
    end
endmodule

bind dcrs_top dcrs_props u_props (.*);
